//--- rtl/esm_pkg.sv
/*
  Shared constants and carrier types for the extended SMRAM decode block.
  Assumes byte-wide configuration accesses and a 36-bit host address.
*/
`default_nettype none

package esm_pkg;

  localparam int ESM_ADDR_W = 36;
  localparam int ESM_MB_W = 16;

  // Configuration byte offsets
  localparam logic [7:0] ESM_OFF_EXT_CTRL = 8'h9e;
  localparam logic [7:0] ESM_OFF_TOM_LO = 8'ha0;
  localparam logic [7:0] ESM_OFF_TOM_HI = 8'ha1;

  // Reset values
  localparam logic [7:0] ESM_EXT_CTRL_RST = 8'h38;
  localparam logic [15:0] ESM_TOM_RST = 16'h0001;

  // Field positions in the extended control byte
  localparam int ESM_BIT_HIGH_EN = 7;
  localparam int ESM_BIT_ERR = 6;
  localparam int ESM_BIT_CACHE = 5;
  localparam int ESM_BIT_L1 = 4;
  localparam int ESM_BIT_L2 = 3;
  localparam int ESM_BIT_SZ_LSB = 1;
  localparam int ESM_BIT_TSEG_EN = 0;
  localparam int ESM_TOM_W = 9;

  // Address windows
  localparam logic [35:0] ESM_HIGH_BASE = 36'h0_feda_0000;
  localparam logic [35:0] ESM_HIGH_LAST = 36'h0_fedb_ffff;
  localparam logic [35:0] ESM_LEGACY_BASE = 36'h0_000a_0000;
  localparam logic [35:0] ESM_LEGACY_LAST = 36'h0_000b_ffff;

  // Sizes in megabyte units
  localparam logic [1:0] ESM_SZ_1MB = 2'h0;
  localparam logic [1:0] ESM_SZ_2MB = 2'h1;
  localparam logic [1:0] ESM_SZ_8MB = 2'h2;
  localparam logic [15:0] ESM_MB_1 = 16'h0001;
  localparam logic [15:0] ESM_MB_2 = 16'h0002;
  localparam logic [15:0] ESM_MB_8 = 16'h0008;
  localparam logic [15:0] ESM_EXT_DRAM_LIMIT_MB = 16'h0100;
  localparam int ESM_TOM_SHIFT = 7;

  typedef struct packed {
    logic [35:0] addr;
    logic smm;
  } esm_req_t;

  typedef struct packed {
    logic [35:0] addr;
    logic to_dram;
    logic to_link;
  } esm_rsp_t;

  typedef struct packed {
    logic high_en;
    logic [1:0] protected_segment_size;
    logic tseg_en;
    logic [8:0] top_of_memory_size;
  } esm_cfg_t;

  typedef struct packed {
    logic high_hit;
    logic tseg_hit;
    logic allowed;
    logic invalid;
    logic normal_dram;
    logic ext_in_use;
  } esm_hit_t;

endpackage

`default_nettype wire

//--- rtl/esm_region_decode.sv
/*
  Combinational classifier of one host request against the high SMRAM
  window, the protected segment and the DRAM limit.
  Assumes configuration inputs are stable flops on the caller's clock.
*/
`default_nettype none

module esm_region_decode (
  // Request and configuration
  input wire esm_pkg::esm_req_t i_req,
  input wire esm_pkg::esm_cfg_t i_cfg,
  input wire logic i_global_smram_enable,
  input wire logic i_smm_space_open,
  input wire logic i_smm_space_lock,
  input wire logic [11:0] i_low_usable_dram_top,
  input wire logic [6:0] i_gfx_stolen_mb,
  // Classification
  output esm_pkg::esm_hit_t o_hit
);
  import esm_pkg::*;

  function automatic logic [15:0] tseg_mb(input logic [1:0] sz);
    case (sz)
      ESM_SZ_1MB: tseg_mb = ESM_MB_1;
      ESM_SZ_2MB: tseg_mb = ESM_MB_2;
      ESM_SZ_8MB: tseg_mb = ESM_MB_8;
      default: tseg_mb = 16'h0000;
    endcase
  endfunction

  logic [15:0] addr_mb;
  logic [15:0] tseg_top;
  logic [15:0] tseg_base;
  logic [15:0] tom_mb;
  logic [15:0] limit_mb;
  logic high_on;
  logic tseg_on;
  logic open_visible;

  always_comb begin
    addr_mb = i_req.addr[35:20];
    high_on = i_global_smram_enable && i_cfg.high_en;
    tseg_on = i_global_smram_enable && i_cfg.tseg_en;
    // Segment sits just under graphics stolen memory
    tseg_top = {4'h0, i_low_usable_dram_top} - {9'h000, i_gfx_stolen_mb};
    tseg_base = tseg_top - tseg_mb(i_cfg.protected_segment_size);
    tom_mb = {i_cfg.top_of_memory_size[ESM_TOM_W-1:0], 7'h00};
    open_visible = i_smm_space_open && !i_smm_space_lock;
    o_hit.ext_in_use = high_on || tseg_on;
    limit_mb = tom_mb;
    if (o_hit.ext_in_use && (tom_mb > ESM_EXT_DRAM_LIMIT_MB)) begin
      limit_mb = ESM_EXT_DRAM_LIMIT_MB;
    end
    o_hit.high_hit = high_on && (i_req.addr >= ESM_HIGH_BASE)
                     && (i_req.addr <= ESM_HIGH_LAST);
    // Reserved size gives an empty segment
    o_hit.tseg_hit = tseg_on && (addr_mb >= tseg_base) && (addr_mb < tseg_top)
                     && (tseg_mb(i_cfg.protected_segment_size) != 16'h0000);
    o_hit.allowed = i_req.smm || open_visible;
    o_hit.invalid = (o_hit.high_hit || o_hit.tseg_hit) && !i_req.smm
                    && !i_smm_space_open;
    o_hit.normal_dram = (addr_mb < {4'h0, i_low_usable_dram_top})
                        && (addr_mb < limit_mb);
  end

endmodule

`default_nettype wire

//--- rtl/esm_decode_ctrl.sv
/*
  Extended SMRAM control and top-of-memory registers with the host
  request router that applies them.
  Assumes configuration cycles and host requests come from logic on i_clk,
  and that lock, open and global enable come from the neighbouring
  SMRAM control register on the same clock.
*/
`default_nettype none

module esm_decode_ctrl (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Configuration space access, byte wide
  input wire logic i_cfg_wr,
  input wire logic i_cfg_rd,
  input wire logic [7:0] i_cfg_addr,
  input wire logic [7:0] i_cfg_wdata,
  output logic [7:0] o_cfg_rdata,
  output logic o_cfg_rvalid,
  // Neighbouring register state and modes
  input wire logic i_global_smram_enable,
  input wire logic i_smm_space_open,
  input wire logic i_smm_space_lock,
  input wire logic [11:0] i_low_usable_dram_top,
  input wire logic [6:0] i_gfx_stolen_mb,
  input wire logic i_trusted_mode,
  input wire logic i_mgmt_engine_mode,
  // Host request and routed answer
  input wire logic i_req_valid,
  input wire esm_pkg::esm_req_t i_req,
  output logic o_rsp_valid,
  output esm_pkg::esm_rsp_t o_rsp,
  // Register state for the rest of the hub
  output logic o_high_smram_enable,
  output logic o_invalid_smram_access_flag,
  output logic [8:0] o_installed_memory_top
);
  import esm_pkg::*;

  esm_cfg_t cfg_q;
  logic err_q;
  logic [7:0] rdata_q;
  logic rvalid_q;
  logic rsp_valid_q;
  esm_rsp_t rsp_q;
  esm_hit_t hit;
  logic ctrl_locked;
  logic tom_locked;
  logic wr_ctrl;
  logic wr_tom_lo;
  logic wr_tom_hi;
  logic err_clear;
  logic err_set;

  function automatic logic [7:0] read_mux(input logic [7:0] off, input esm_cfg_t c,
                                          input logic e);
    case (off)
      // Cacheability bits are hardwired to one
      ESM_OFF_EXT_CTRL: read_mux = {c.high_en, e, 3'h7, c.protected_segment_size, c.tseg_en};
      ESM_OFF_TOM_LO: read_mux = c.top_of_memory_size[7:0];
      ESM_OFF_TOM_HI: read_mux = {7'h00, c.top_of_memory_size[8]};
      default: read_mux = 8'h00;
    endcase
  endfunction

  esm_region_decode u_decode (
    .i_req(i_req),
    .i_cfg(cfg_q),
    .i_global_smram_enable(i_global_smram_enable),
    .i_smm_space_open(i_smm_space_open),
    .i_smm_space_lock(i_smm_space_lock),
    .i_low_usable_dram_top(i_low_usable_dram_top),
    .i_gfx_stolen_mb(i_gfx_stolen_mb),
    .o_hit(hit)
  );

  always_comb begin
    ctrl_locked = i_trusted_mode || i_smm_space_lock;
    tom_locked = i_trusted_mode || i_mgmt_engine_mode || i_smm_space_lock;
    wr_ctrl = i_cfg_wr && (i_cfg_addr == ESM_OFF_EXT_CTRL);
    wr_tom_lo = i_cfg_wr && (i_cfg_addr == ESM_OFF_TOM_LO);
    wr_tom_hi = i_cfg_wr && (i_cfg_addr == ESM_OFF_TOM_HI);
    err_clear = wr_ctrl && i_cfg_wdata[ESM_BIT_ERR];
    err_set = i_req_valid && hit.invalid;
  end

  // Extended control fields; cacheability bits are not stored
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cfg_q.high_en <= ESM_EXT_CTRL_RST[ESM_BIT_HIGH_EN];
      cfg_q.protected_segment_size <= ESM_EXT_CTRL_RST[ESM_BIT_SZ_LSB +: 2];
      cfg_q.tseg_en <= ESM_EXT_CTRL_RST[ESM_BIT_TSEG_EN];
    end else if (wr_ctrl && !ctrl_locked) begin
      cfg_q.high_en <= i_cfg_wdata[ESM_BIT_HIGH_EN];
      cfg_q.protected_segment_size <= i_cfg_wdata[ESM_BIT_SZ_LSB +: 2];
      cfg_q.tseg_en <= i_cfg_wdata[ESM_BIT_TSEG_EN];
    end
  end

  // Top of memory, one byte lane at a time
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cfg_q.top_of_memory_size <= ESM_TOM_RST[8:0];
    end else if (!tom_locked) begin
      if (wr_tom_lo) begin
        cfg_q.top_of_memory_size[7:0] <= i_cfg_wdata;
      end
      if (wr_tom_hi) begin
        cfg_q.top_of_memory_size[8] <= i_cfg_wdata[0];
      end
    end
  end

  // A new violation in the clearing cycle wins over the clear
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      err_q <= ESM_EXT_CTRL_RST[ESM_BIT_ERR];
    end else if (err_set) begin
      err_q <= 1'b1;
    end else if (err_clear) begin
      err_q <= 1'b0;
    end
  end

  // Read answer one cycle after the strobe
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= i_cfg_rd;
      if (i_cfg_rd) begin
        rdata_q <= read_mux(i_cfg_addr, cfg_q, err_q);
      end
    end
  end

  // Request routing, one cycle of latency
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rsp_valid_q <= 1'b0;
      rsp_q <= '0;
    end else begin
      rsp_valid_q <= i_req_valid;
      if (i_req_valid) begin
        rsp_q.addr <= i_req.addr;
        rsp_q.to_dram <= 1'b0;
        rsp_q.to_link <= 1'b1;
        if (hit.high_hit && hit.allowed) begin
          // Offset into the window lands in the legacy range
          rsp_q.addr <= i_req.addr - ESM_HIGH_BASE + ESM_LEGACY_BASE;
          rsp_q.to_dram <= 1'b1;
          rsp_q.to_link <= 1'b0;
        end else if (hit.tseg_hit) begin
          rsp_q.to_dram <= hit.allowed;
          rsp_q.to_link <= !hit.allowed;
        end else if (!hit.high_hit && hit.normal_dram) begin
          rsp_q.to_dram <= 1'b1;
          rsp_q.to_link <= 1'b0;
        end
      end
    end
  end

  always_comb begin
    o_cfg_rdata = rdata_q;
    o_cfg_rvalid = rvalid_q;
    o_rsp_valid = rsp_valid_q;
    o_rsp = rsp_q;
    o_high_smram_enable = cfg_q.high_en;
    o_invalid_smram_access_flag = err_q;
    o_installed_memory_top = cfg_q.top_of_memory_size;
  end

  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  sequence s_high_smm_req;
    i_req_valid && i_req.smm && i_global_smram_enable && cfg_q.high_en
      && (i_req.addr >= ESM_HIGH_BASE) && (i_req.addr <= ESM_HIGH_LAST);
  endsequence

  sequence s_legacy_answer;
    o_rsp_valid && o_rsp.to_dram && (o_rsp.addr >= ESM_LEGACY_BASE)
      && (o_rsp.addr <= ESM_LEGACY_LAST);
  endsequence

  property p_high_remap;
    s_high_smm_req |=> s_legacy_answer;
  endproperty
  a_high_remap: assert property (p_high_remap)
    else $error("high window request not remapped to legacy range");

  property p_high_needs_global;
    (i_req_valid && !i_global_smram_enable) |-> !hit.high_hit && !hit.tseg_hit;
  endproperty
  a_high_needs_global: assert property (p_high_needs_global)
    else $error("extended window decoded without global enable");

  property p_err_set;
    (i_req_valid && !i_req.smm && !i_smm_space_open && hit.high_hit)
      |=> o_invalid_smram_access_flag;
  endproperty
  a_err_set: assert property (p_err_set)
    else $error("invalid access did not raise error flag");

  property p_err_sticky;
    (o_invalid_smram_access_flag && !err_clear)
      |=> o_invalid_smram_access_flag [*1];
  endproperty
  a_err_sticky: assert property (p_err_sticky)
    else $error("error flag dropped without a clear");

  property p_err_w1c;
    (err_clear && !err_set) |=> !o_invalid_smram_access_flag;
  endproperty
  a_err_w1c: assert property (p_err_w1c)
    else $error("writing one did not clear error flag");

  sequence s_ctrl_read;
    i_cfg_rd && (i_cfg_addr == ESM_OFF_EXT_CTRL);
  endsequence

  property p_cache_ones;
    s_ctrl_read |=> o_cfg_rvalid && (o_cfg_rdata[5:3] == 3'h7);
  endproperty
  a_cache_ones: assert property (p_cache_ones)
    else $error("cacheability bits did not read as one");

  property p_ctrl_lock;
    (wr_ctrl && ctrl_locked) |=> $stable(cfg_q.high_en) && $stable(cfg_q.protected_segment_size)
      && $stable(cfg_q.tseg_en);
  endproperty
  a_ctrl_lock: assert property (p_ctrl_lock)
    else $error("locked control field changed");

  property p_tom_lock;
    tom_locked |=> $stable(o_installed_memory_top);
  endproperty
  a_tom_lock: assert property (p_tom_lock)
    else $error("top of memory changed while locked");

  property p_tseg_block;
    (i_req_valid && hit.tseg_hit && !i_req.smm && !(i_smm_space_open && !i_smm_space_lock))
      |=> o_rsp_valid && o_rsp.to_link && !o_rsp.to_dram;
  endproperty
  a_tseg_block: assert property (p_tseg_block)
    else $error("non-SMM segment access not sent to downstream link");

  property p_ext_limit;
    (i_req_valid && hit.ext_in_use && !hit.high_hit && !hit.tseg_hit
      && (i_req.addr[35:20] >= ESM_EXT_DRAM_LIMIT_MB)) |=> o_rsp.to_link;
  endproperty
  a_ext_limit: assert property (p_ext_limit)
    else $error("DRAM above 256 MB reached with extended SMRAM in use");

  property p_rsv_zero;
    (i_cfg_rd && (i_cfg_addr == ESM_OFF_TOM_HI)) |=> (o_cfg_rdata[7:1] == 7'h00);
  endproperty
  a_rsv_zero: assert property (p_rsv_zero)
    else $error("reserved top of memory bits read nonzero");

  property p_high_off;
    (i_req_valid && !(i_global_smram_enable && cfg_q.high_en)) |-> !hit.high_hit;
  endproperty
  a_high_off: assert property (p_high_off)
    else $error("high window decoded while disabled");

  property p_tseg_off;
    (i_req_valid && !(i_global_smram_enable && cfg_q.tseg_en)) |-> !hit.tseg_hit;
  endproperty
  a_tseg_off: assert property (p_tseg_off)
    else $error("segment decoded while disabled");

  property p_tseg_rsvd;
    (i_req_valid && (cfg_q.protected_segment_size == 2'h3)) |-> !hit.tseg_hit;
  endproperty
  a_tseg_rsvd: assert property (p_tseg_rsvd)
    else $error("reserved segment size decoded a hit");

  sequence s_tseg_smm_req;
    i_req_valid && i_req.smm && hit.tseg_hit && !hit.high_hit;
  endsequence

  sequence s_dram_same_addr;
    o_rsp_valid && o_rsp.to_dram && !o_rsp.to_link && (o_rsp.addr == $past(i_req.addr));
  endsequence

  property p_tseg_smm;
    s_tseg_smm_req |=> s_dram_same_addr;
  endproperty
  a_tseg_smm: assert property (p_tseg_smm)
    else $error("SMM segment request not sent to DRAM");

  property p_open_visible;
    (i_req_valid && hit.tseg_hit && !hit.high_hit && i_smm_space_open && !i_smm_space_lock)
      |=> s_dram_same_addr;
  endproperty
  a_open_visible: assert property (p_open_visible)
    else $error("open segment not visible outside SMM");

  property p_err_tseg;
    (i_req_valid && !i_req.smm && !i_smm_space_open && hit.tseg_hit)
      |=> o_invalid_smram_access_flag;
  endproperty
  a_err_tseg: assert property (p_err_tseg)
    else $error("invalid segment access did not raise error flag");

  property p_err_quiet;
    (!o_invalid_smram_access_flag && !(i_req_valid && !i_req.smm && !i_smm_space_open
      && (hit.high_hit || hit.tseg_hit))) |=> !o_invalid_smram_access_flag;
  endproperty
  a_err_quiet: assert property (p_err_quiet)
    else $error("error flag rose without an invalid access");

  property p_ctrl_write;
    (wr_ctrl && !ctrl_locked) |=> (cfg_q.high_en == $past(i_cfg_wdata[ESM_BIT_HIGH_EN]))
      && (cfg_q.protected_segment_size == $past(i_cfg_wdata[ESM_BIT_SZ_LSB +: 2]))
      && (cfg_q.tseg_en == $past(i_cfg_wdata[ESM_BIT_TSEG_EN]));
  endproperty
  a_ctrl_write: assert property (p_ctrl_write)
    else $error("unlocked control write did not land");

  property p_tom_write;
    (wr_tom_lo && !tom_locked) |=> (o_installed_memory_top[7:0] == $past(i_cfg_wdata));
  endproperty
  a_tom_write: assert property (p_tom_write)
    else $error("unlocked top of memory write did not land");

  property p_tom_limit;
    (i_req_valid && !hit.high_hit && !hit.tseg_hit && (i_req.addr[35:27] >= cfg_q.top_of_memory_size))
      |=> o_rsp.to_link && !o_rsp.to_dram;
  endproperty
  a_tom_limit: assert property (p_tom_limit)
    else $error("request above top of memory sent to DRAM");

endmodule

`default_nettype wire

//--- sim/esm_host_model.sv
/*
  Processor-side request source for the extended SMRAM decode block.
  Assumes the bench calls send once the previous request has been taken.
*/
`default_nettype none

module esm_host_model (
  // Clock
  input wire logic i_clk,
  // Request to the hub
  output logic o_req_valid,
  output esm_pkg::esm_req_t o_req
);
  timeunit 1ns;
  timeprecision 1ns;
  import esm_pkg::*;

  initial begin
    o_req_valid = 1'b0;
    o_req = '0;
  end

  task automatic send(input logic [35:0] a, input logic s, input int gap);
    repeat (gap) @(posedge i_clk);
    @(posedge i_clk);
    o_req_valid <= 1'b1;
    o_req <= '{addr: a, smm: s};
    @(posedge i_clk);
    o_req_valid <= 1'b0;
    // Idle lines never keep the last request
    o_req <= ~o_req;
  endtask
endmodule

`default_nettype wire

//--- sim/test_extended_smram_decode_control.sv
/*
  Self-checking bench for the extended SMRAM decode block.
  Assumes a single 25 MHz clock and that the bench plays the neighbour
  register that holds lock, open and the global enable.
*/
`default_nettype none

module test_extended_smram_decode_control;
  timeunit 1ns;
  timeprecision 1ns;
  import esm_pkg::*;

  logic clk = 0, rstn = 0, wr = 0, rd = 0, gse = 0, sso = 0, ssl = 0, trm = 0, mem = 0;
  logic [7:0] ca = 8'h00, wd = 8'h00, rdata;
  logic [11:0] lt = 12'h100;
  logic [6:0] st = 7'h08;
  logic rvalid, rsv, rv, hio, flag;
  logic [8:0] tomo;
  esm_req_t rq;
  esm_rsp_t rs;
  logic hi = 0, en = 0, fl = 0;
  logic [1:0] sz = 2'h0;
  logic [8:0] top_of_memory_size = 9'h001;
  int bad_count = 0, total_checks = 0, cyc = 0;
  integer seed = 33;

  esm_host_model i_host (.i_clk(clk), .o_req_valid(rv), .o_req(rq));

  esm_decode_ctrl i_dut (
    .i_clk(clk), .i_rstn(rstn), .i_cfg_wr(wr), .i_cfg_rd(rd), .i_cfg_addr(ca),
    .i_cfg_wdata(wd), .o_cfg_rdata(rdata), .o_cfg_rvalid(rvalid),
    .i_global_smram_enable(gse), .i_smm_space_open(sso), .i_smm_space_lock(ssl),
    .i_low_usable_dram_top(lt), .i_gfx_stolen_mb(st), .i_trusted_mode(trm),
    .i_mgmt_engine_mode(mem), .i_req_valid(rv), .i_req(rq), .o_rsp_valid(rsv),
    .o_rsp(rs), .o_high_smram_enable(hio), .o_invalid_smram_access_flag(flag),
    .o_installed_memory_top(tomo)
  );

  always #20 clk = ~clk;

  // Generous ceiling: the whole run needs well under half of it
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      results();
    end
  end

  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] img(input logic [7:0] a);
    case (a)
      ESM_OFF_EXT_CTRL: img = {hi, fl, 3'h7, sz, en};
      ESM_OFF_TOM_LO: img = top_of_memory_size[7:0];
      ESM_OFF_TOM_HI: img = {7'h00, top_of_memory_size[8]};
      default: img = 8'h00;
    endcase
  endfunction

  // {flag set, routed address, to_dram, to_link}
  function automatic logic [38:0] pred(input logic [35:0] a, input logic s);
    logic [15:0] mb, top, base, lim;
    logic ok, dr;
    mb = a[35:20];
    top = {4'h0, lt} - {9'h000, st};
    base = top - (sz == 2'h0 ? 16'h0001 : sz == 2'h1 ? 16'h0002 : 16'h0008);
    ok = s || (sso && !ssl);
    lim = {top_of_memory_size, 7'h00};
    if (gse && (hi || en) && lim > 16'h0100) lim = 16'h0100;
    dr = mb < {4'h0, lt} && mb < lim;
    if (gse && hi && a >= ESM_HIGH_BASE && a <= ESM_HIGH_LAST)
      pred = {!s && !sso, ok ? a - 36'h0_fed0_0000 : a, ok, !ok};
    else if (gse && en && sz != 2'h3 && mb >= base && mb < top)
      pred = {!s && !sso, a, ok, !ok};
    else pred = {1'b0, a, dr, !dr};
  endfunction

  task automatic rst;
    @(posedge clk);
    rstn <= 1'b0;
    ssl <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    {hi, sz, en, fl, top_of_memory_size} = {5'h00, 9'h001};
  endtask

  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    ca <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
    if (a == ESM_OFF_EXT_CTRL) begin
      if (!trm && !ssl) {hi, sz, en} = {d[7], d[2:1], d[0]};
      if (d[6]) fl = 1'b0;
    end
    if (a == ESM_OFF_TOM_LO && !(trm || mem || ssl)) top_of_memory_size[7:0] = d;
    if (a == ESM_OFF_TOM_HI && !(trm || mem || ssl)) top_of_memory_size[8] = d[0];
  endtask

  task automatic rd8(input logic [7:0] a);
    @(posedge clk);
    rd <= 1'b1;
    ca <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(64'(rvalid), 64'h1);
    chk(64'(rdata), 64'(img(a)));
    chk(64'({hio, tomo}), 64'({hi, top_of_memory_size}));
  endtask

  task automatic req(input logic [35:0] a, input logic s, input int gap);
    logic [38:0] p;
    p = pred(a, s);
    i_host.send(a, s, gap);
    #1;
    if (p[38]) fl = 1'b1;
    chk(64'(rsv), 64'h1);
    chk(64'(rs), 64'(p[37:0]));
    chk(64'(flag), 64'(fl));
  endtask

  task automatic burst(input int n);
    logic [15:0] r;
    logic [35:0] a;
    repeat (n) begin
      r = 16'($random(seed));
      case (r[1:0])
        2'h0: a = ESM_HIGH_BASE - 36'h8000 + {17'h0, r, 3'h0};
        2'h1: a = {4'h0, lt - 12'(st) - 12'h009, 20'h0} + {12'h0, r, 8'h0};
        2'h2: a = {7'h0, r, 13'h0};
        default: a = 36'(unsigned'($random(seed)));
      endcase
      req(a, r[2], r[3] ? 2 : 0);
    end
  endtask

  logic [7:0] regs [6] = '{8'h9e, 8'ha0, 8'ha1, 8'h9f, 8'h9d, 8'ha2};
  logic [7:0] cfgs [7] = '{8'h00, 8'h80, 8'h81, 8'h83, 8'h85, 8'h87, 8'h01};

  initial begin
    rst();
    foreach (regs[i]) rd8(regs[i]);
    wr8(8'h9e, 8'hff);
    rd8(8'h9e);
    wr8(8'h9e, 8'h00);
    wr8(8'ha1, 8'hff);
    wr8(8'ha0, 8'h04);
    rd8(8'ha1);
    // Small top of memory so the 128 MB granule cuts DRAM below the low top
    wr8(8'ha1, 8'h00);
    for (int k = 0; k < 2; k++) begin
      lt <= k ? 12'h200 : 12'h100;
      wr8(8'ha0, k ? 8'h04 : 8'h01);
      foreach (cfgs[c]) begin
        gse <= c != 6;
        for (int o = 0; o < 2; o++) begin
          sso <= o[0];
          // Zero in bit 6 must leave a set flag alone
          wr8(8'h9e, cfgs[c]);
          req(ESM_HIGH_BASE, 1'b0, 0);
          req(ESM_HIGH_LAST, 1'b1, 0);
          req(ESM_HIGH_LAST + 36'h1, 1'b1, 0);
          for (int m = 0; m <= 9; m++) req({4'h0, lt - 12'(st) - 12'(m), 20'h0}, m[0], 0);
          burst(30);
          rd8(8'h9e);
        end
        wr8(8'h9e, 8'h40);
        rd8(8'h9e);
      end
    end
    wr8(8'h9e, 8'h81);
    trm <= 1'b1;
    wr8(8'h9e, 8'h06);
    wr8(8'ha0, 8'h07);
    rd8(8'h9e);
    rd8(8'ha0);
    trm <= 1'b0;
    mem <= 1'b1;
    wr8(8'h9e, 8'h84);
    wr8(8'ha0, 8'h07);
    rd8(8'ha0);
    mem <= 1'b0;
    // Neighbour keeps lock set until the next reset
    gse <= 1'b1;
    ssl <= 1'b1;
    wr8(8'h9e, 8'h81);
    wr8(8'ha1, 8'h01);
    rd8(8'h9e);
    rd8(8'ha1);
    burst(30);
    rst();
    rd8(8'h9e);
    chk(64'(flag), 64'h0);
    results();
  end
endmodule

`default_nettype wire
